//--- hw/rog_defs.svh
// Register offsets, field positions, reset values and timing constants
// Assumes inclusion by the package and the register-bank module only
`ifndef ROG_DEFS_SVH
`define ROG_DEFS_SVH

// Register offsets on the serial bus
`define ROG_OFS_CONV 8'h9c
`define ROG_OFS_PGD 8'h9d
`define ROG_OFS_SWT 8'h9f

// Converter register fields
`define ROG_CONV_MODE_HI 5
`define ROG_CONV_MODE_LO 3
`define ROG_CONV_OFF_HI 2
`define ROG_CONV_OFF_LO 0
`define ROG_CONV_RW_MASK 8'h3f

// Delay register fields
`define ROG_PGD2_HI 7
`define ROG_PGD2_LO 5
`define ROG_PGD4_HI 4
`define ROG_PGD4_LO 2
`define ROG_PGD1_HI 1
`define ROG_PGD1_LO 0

// Switch register fields
`define ROG_SWT_OFF_HI 7
`define ROG_SWT_OFF_LO 4

// Reset values
`define ROG_RST_CONV 8'h27
`define ROG_RST_PGD 8'h00
`define ROG_RST_SWT 8'hf0

// Answer for unmapped offsets
`define ROG_RD_UNMAPPED 8'h00

// Clock and delay timebase
`define ROG_CLK_NS 40
`define ROG_TICK_NS 100000
`define ROG_TICK_CYC (`ROG_TICK_NS / `ROG_CLK_NS)
`define ROG_TICK_PER_MS 10

// Delay steps in milliseconds
`define ROG_DLY_0 0
`define ROG_DLY_1 5
`define ROG_DLY_2 10
`define ROG_DLY_3 15
`define ROG_DLY_4 20
`define ROG_DLY_5 50
`define ROG_DLY_6 75
`define ROG_DLY_7 100

// Serial bus byte handling
`define ROG_BITS_PER_BYTE 4'd8
`define ROG_DEV_ADDR 7'h5e

`endif

//--- hw/rog_pkg.sv
// Types shared by the register bank: output sources, serial states, carriers
// Assumes rog_defs.svh is reachable on the include path
package rog_pkg;
`include "rog_defs.svh"

	// Source that drives a general-purpose output
	typedef enum logic [1:0] {
		ROG_SRC_GOOD,
		ROG_SRC_LVL,
		ROG_SRC_HOST
	} rog_src_t;

	// Serial slave states
	typedef enum logic [2:0] {
		ROG_S_IDLE,
		ROG_S_ADDR,
		ROG_S_PTR,
		ROG_S_WDATA,
		ROG_S_ACK,
		ROG_S_TX,
		ROG_S_RACK
	} rog_state_t;

	// One register write from the serial slave
	typedef struct packed {
		logic stb;
		logic [7:0] addr;
		logic [7:0] data;
	} rog_wr_t;

	// Converter mode and force-off register
	typedef struct packed {
		logic [1:0] rsvd;
		logic [2:0] mode_sel;
		logic [2:0] force_off_n;
	} rog_conv_t;

	// Power-good delay register
	typedef struct packed {
		logic [2:0] out2_good_delay;
		logic [2:0] out4_good_delay;
		logic [1:0] out1_good_delay;
	} rog_pgd_t;

	// Switch and termination force-off register
	typedef struct packed {
		logic [3:0] off_n;
		logic [3:0] rsvd;
	} rog_swt_t;
endpackage

//--- hw/rog_regs.sv
// Override and power-good delay register bank behind a serial two-wire slave
// Assumes scl/sda already synchronous to mclk; open-drain wire resolved outside
`timescale 1ns/100ps

// Delays one good level by a programmed tick count, restarting on any drop
module rog_delay #(
	parameter int CW = 10
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic src_good,
	input wire logic [CW-1:0] limit,
	output logic good_reg
);
	logic [CW-1:0] cnt_reg;
	logic reached;

	assign reached = (cnt_reg >= limit);

	// Count ticks while the source stays good; any drop restarts [R3] [R13]
	always_ff @(posedge mclk) begin
		if (!rst_n || !src_good) begin
			cnt_reg <= '0;
			good_reg <= 1'b0;
		end else if (reached) begin
			good_reg <= 1'b1;
		end else if (tick) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end
endmodule

// Function
// R1 - Mode bits 5,4,3 pick automatic (0) or forced PWM (1) per converter.
// R2 - Bits 2,1,0 at zero force each converter off regardless of enable pins.
// R3 - Power-good asserts only after programmed delay from all rails in range.
// R4 - Output two delay bits 7:5 map 0,5,10,15,20,50,75,100 ms.
// R5 - Output four delay bits 4:2 use the same eight-step encoding.
// R6 - Output one delay bits 1:0 map 0,5,10,15 ms.
// R7 - Each delay is held within plus or minus ten percent.
// R8 - Each output is power-good, level shifter, or host-set level.
// R9 - Host-driven outputs one and four ignore delay bits; reset zero.
// R10 - Output two delay ignored only if host-driven and not used for termination.
// R11 - Bits 7:4 of switch register at zero force those rails off.
// R12 - Host writes zeros to the low four switch register bits.
// R13 - Rail leaving range before expiry restarts delay, output stays low.
module rog_regs
	import rog_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = `ROG_DEV_ADDR,
	parameter logic [7:0] RST_CONV = `ROG_RST_CONV,
	parameter logic [7:0] RST_PGD = `ROG_RST_PGD,
	parameter logic [7:0] RST_SWT = `ROG_RST_SWT
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [2:0] conv_pin_en,
	input wire logic [3:0] switch_pin_en,
	input wire logic [2:0] group_good,
	input wire logic [2:0] lvl_in,
	input wire logic [2:0] host_lvl,
	input wire rog_src_t out1_src,
	input wire rog_src_t out2_src,
	input wire rog_src_t out4_src,
	input wire logic out2_term_use,
	output logic [2:0] conv_en,
	output logic [2:0] conv_fpwm,
	output logic [3:0] switch_en,
	output logic general_output_one,
	output logic general_output_two,
	output logic general_output_four
);
	localparam int TICK_CYC = `ROG_TICK_CYC;
	localparam int TW = $clog2(TICK_CYC);

	rog_conv_t conv_reg;
	rog_pgd_t pgd_reg;
	rog_swt_t swt_reg;
	rog_wr_t wr_reg;
	rog_state_t state_reg;
	rog_state_t after_reg;
	logic [7:0] shreg_reg;
	logic [7:0] ptr_reg;
	logic [3:0] cnt_reg;
	logic rw_reg;
	logic scl_d_reg;
	logic sda_d_reg;
	logic [TW-1:0] div_reg;
	logic tick_reg;
	logic [2:0] dly_good;
	logic [2:0] out_good_src;
	logic [9:0] lim1;
	logic [9:0] lim2;
	logic [9:0] lim4;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic byte_full;
	logic [7:0] rdata;

	// Bus edge and condition detection
	assign scl_rise = scl_in && !scl_d_reg;
	assign scl_fall = !scl_in && scl_d_reg;
	assign bus_start = scl_in && scl_d_reg && sda_d_reg && !sda_in;
	assign bus_stop = scl_in && scl_d_reg && !sda_d_reg && sda_in;
	assign byte_full = (cnt_reg == `ROG_BITS_PER_BYTE);

	// Read-back mux; unmapped offsets answer zero
	assign rdata = (ptr_reg == `ROG_OFS_CONV) ? (conv_reg & `ROG_CONV_RW_MASK) :
		(ptr_reg == `ROG_OFS_PGD) ? pgd_reg :
		(ptr_reg == `ROG_OFS_SWT) ? swt_reg : `ROG_RD_UNMAPPED;

	// Delay code to tick count, one tick is a tenth of a millisecond
	function automatic logic [9:0] dly_ticks(input logic [2:0] code);
		int ms;
		case (code)
			3'h0: ms = `ROG_DLY_0;
			3'h1: ms = `ROG_DLY_1;
			3'h2: ms = `ROG_DLY_2;
			3'h3: ms = `ROG_DLY_3;
			3'h4: ms = `ROG_DLY_4;
			3'h5: ms = `ROG_DLY_5;
			3'h6: ms = `ROG_DLY_6;
			default: ms = `ROG_DLY_7;
		endcase
		return 10'(ms * `ROG_TICK_PER_MS);
	endfunction

	// Delay limits per output; output one uses only the first four steps
	assign lim2 = dly_ticks(pgd_reg.out2_good_delay); // [R4]
	assign lim4 = dly_ticks(pgd_reg.out4_good_delay); // [R5]
	assign lim1 = dly_ticks({1'b0, pgd_reg.out1_good_delay}); // [R6]

	// Good source: grouped rails in range, or the level-shifter input
	assign out_good_src[0] = (out1_src == ROG_SRC_LVL) ? lvl_in[0] : group_good[0]; // [R8]
	assign out_good_src[1] = (out2_src == ROG_SRC_LVL) ? lvl_in[1] : group_good[1]; // [R8]
	assign out_good_src[2] = (out4_src == ROG_SRC_LVL) ? lvl_in[2] : group_good[2]; // [R8]

	// Bus sampling history
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_in;
			sda_d_reg <= sda_in;
		end
	end

	// Timebase: 100 us tick keeps every step well inside ten percent
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			div_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= (div_reg == TW'(TICK_CYC - 1)); // [R7]
			div_reg <= (div_reg == TW'(TICK_CYC - 1)) ? '0 : div_reg + 1'b1;
		end
	end

	// One delay counter per output, each restarting on any drop of its source [R3] [R13]
	rog_delay #(.CW(10)) u_dly1 (
		.mclk(mclk), .rst_n(rst_n), .tick(tick_reg),
		.src_good(out_good_src[0]), .limit(lim1), .good_reg(dly_good[0])
	);
	rog_delay #(.CW(10)) u_dly2 (
		.mclk(mclk), .rst_n(rst_n), .tick(tick_reg),
		.src_good(out_good_src[1]), .limit(lim2), .good_reg(dly_good[1])
	);
	rog_delay #(.CW(10)) u_dly4 (
		.mclk(mclk), .rst_n(rst_n), .tick(tick_reg),
		.src_good(out_good_src[2]), .limit(lim4), .good_reg(dly_good[2])
	);

	// Serial slave: address, register pointer, data with pointer auto-increment
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_reg <= ROG_S_IDLE;
			after_reg <= ROG_S_IDLE;
			shreg_reg <= '0;
			ptr_reg <= '0;
			cnt_reg <= '0;
			rw_reg <= 1'b0;
			sda_oe <= 1'b0;
			wr_reg <= '0;
		end else begin
			wr_reg.stb <= 1'b0;
			if (bus_start) begin
				state_reg <= ROG_S_ADDR;
				cnt_reg <= '0;
				sda_oe <= 1'b0;
			end else if (bus_stop) begin
				state_reg <= ROG_S_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (state_reg)
					ROG_S_ADDR, ROG_S_PTR, ROG_S_WDATA: begin
						if (scl_rise && !byte_full) begin
							shreg_reg <= {shreg_reg[6:0], sda_in};
							cnt_reg <= cnt_reg + 1'b1;
						end else if (scl_fall && byte_full) begin
							sda_oe <= 1'b1; // Acknowledge
							state_reg <= ROG_S_ACK;
							after_reg <= ROG_S_WDATA;
							if (state_reg == ROG_S_ADDR) begin
								rw_reg <= shreg_reg[0];
								after_reg <= shreg_reg[0] ? ROG_S_TX : ROG_S_PTR;
								if (shreg_reg[7:1] != DEV_ADDR) begin
									sda_oe <= 1'b0;
									state_reg <= ROG_S_IDLE;
								end
							end else if (state_reg == ROG_S_PTR) begin
								ptr_reg <= shreg_reg;
							end else begin
								wr_reg <= '{stb: 1'b1, addr: ptr_reg, data: shreg_reg};
								ptr_reg <= ptr_reg + 1'b1;
							end
						end
					end
					ROG_S_ACK: begin
						if (scl_fall) begin
							cnt_reg <= '0;
							state_reg <= after_reg;
							sda_oe <= 1'b0;
							if (after_reg == ROG_S_TX) begin
								shreg_reg <= rdata;
								sda_oe <= !rdata[7];
								cnt_reg <= 4'd1;
								ptr_reg <= ptr_reg + 1'b1;
							end
						end
					end
					ROG_S_TX: begin
						if (scl_fall) begin
							if (byte_full) begin
								sda_oe <= 1'b0;
								state_reg <= ROG_S_RACK;
							end else begin
								sda_oe <= !shreg_reg[6];
								shreg_reg <= {shreg_reg[6:0], 1'b0};
								cnt_reg <= cnt_reg + 1'b1;
							end
						end
					end
					ROG_S_RACK: begin
						if (scl_rise) begin
							state_reg <= sda_in ? ROG_S_IDLE : ROG_S_ACK; // Stop on no-ack
							after_reg <= ROG_S_TX;
						end
					end
					default: begin
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	// Register writes; reserved low switch bits stored as written [R12]
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			conv_reg <= RST_CONV;
			pgd_reg <= RST_PGD;
			swt_reg <= RST_SWT;
		end else if (wr_reg.stb) begin
			if (wr_reg.addr == `ROG_OFS_CONV)
				conv_reg <= wr_reg.data & `ROG_CONV_RW_MASK;
			if (wr_reg.addr == `ROG_OFS_PGD)
				pgd_reg <= wr_reg.data;
			if (wr_reg.addr == `ROG_OFS_SWT)
				swt_reg <= wr_reg.data;
		end
	end

	// Rail enables, mode outputs and general-purpose outputs
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sda_out <= 1'b0;
			conv_en <= '0;
			conv_fpwm <= '0;
			switch_en <= '0;
			general_output_one <= 1'b0;
			general_output_two <= 1'b0;
			general_output_four <= 1'b0;
		end else begin
			sda_out <= 1'b0; // Open drain, only ever pulls low
			conv_fpwm <= conv_reg.mode_sel; // [R1]
			conv_en <= conv_pin_en & conv_reg.force_off_n; // [R2]
			// Termination also waits on delayed output two when tied to it
			switch_en <= switch_pin_en & swt_reg.off_n
				& {3'b111, !out2_term_use || dly_good[1]}; // [R11] [R10]
			general_output_one <= (out1_src == ROG_SRC_HOST) ? host_lvl[0] : dly_good[0]; // [R9]
			general_output_two <= (out2_src == ROG_SRC_HOST) ? host_lvl[1] : dly_good[1]; // [R10]
			general_output_four <= (out4_src == ROG_SRC_HOST) ? host_lvl[2] : dly_good[2]; // [R9]
		end
	end
endmodule

//--- verification/rog_host.sv
// Serial host model: bit-banged two-wire register writes and reads
// Assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/100ps
module rog_host (
	input wire logic mclk,
	input wire logic sda_in,
	output logic scl,
	output logic sda
);
	// Bus idles released
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end

	// Wait a number of clock edges
	task automatic w(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// One bit out, one bit sampled mid-way through scl high
	task automatic bt(input logic b, output logic r);
		sda <= b;
		w(2);
		scl <= 1'b1;
		w(3);
		r = sda_in;
		w(1);
		scl <= 1'b0;
		w(2);
	endtask

	// Eight bits MSB first, then the ninth bit given as nk
	task automatic by(input logic [7:0] d, input logic nk, output logic [7:0] q);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bt(d[i], q[i]);
		end
		bt(nk, a);
	endtask

	// Start or repeated start
	task automatic st();
		sda <= 1'b1;
		w(2);
		scl <= 1'b1;
		w(3);
		sda <= 1'b0;
		w(3);
		scl <= 1'b0;
		w(2);
	endtask

	// Stop
	task automatic sp();
		sda <= 1'b0;
		w(2);
		scl <= 1'b1;
		w(3);
		sda <= 1'b1;
		w(3);
	endtask

	// Register write; reserved switch bits always go out as zero
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		st();
		by(8'hbc, 1'b1, q);
		by(a, 1'b1, q);
		by((a == 8'h9f) ? (d & 8'hf0) : d, 1'b1, q);
		sp();
	endtask

	// Register read: set pointer, repeated start, one byte then nack
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] q;
		st();
		by(8'hbc, 1'b1, q);
		by(a, 1'b1, q);
		st();
		by(8'hbd, 1'b1, q);
		by(8'hff, 1'b1, d);
		sp();
	endtask
endmodule

//--- verification/rog_regs_bench.sv
// Self-checking bench for the override and delay register bank
// Assumes a pulled-up data wire resolved here and a 25 MHz clock
`timescale 1ns/100ps
module rog_regs_bench;
	import rog_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic scl;
	logic hsda;
	logic sda_out;
	logic sda_oe;
	logic [2:0] pe = 3'h7;
	logic [3:0] swp = 4'hf;
	logic [2:0] gg = 3'h0;
	logic [2:0] lv = 3'h0;
	logic [2:0] hl = 3'h2;
	rog_src_t s1 = ROG_SRC_GOOD;
	rog_src_t s2 = ROG_SRC_HOST;
	rog_src_t s4 = ROG_SRC_LVL;
	logic tu = 1'b1;
	logic [2:0] conv_en;
	logic [2:0] conv_fpwm;
	logic [3:0] switch_en;
	logic o1;
	logic o2;
	logic o4;
	logic [7:0] rv [4] = '{8'h27, 8'h00, 8'h00, 8'hf0};
	int errors = 0;
	int comparisons = 0;
	int cyc = 0;
	wire sda_w = hsda & ~sda_oe;

	// Design and serial host
	rog_regs u_rog_regs (.mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .conv_pin_en(pe), .switch_pin_en(swp),
		.group_good(gg), .lvl_in(lv), .host_lvl(hl), .out1_src(s1),
		.out2_src(s2), .out4_src(s4), .out2_term_use(tu),
		.conv_en(conv_en), .conv_fpwm(conv_fpwm), .switch_en(switch_en),
		.general_output_one(o1), .general_output_two(o2), .general_output_four(o4));
	rog_host u_rog_host (.mclk(mclk), .sda_in(sda_w), .scl(scl), .sda(hsda));

	always #20 mclk = ~mclk;

	// Compare and count
	task automatic ck(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// Verdict and end of run
	task automatic close_out();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 50000) begin
			errors++;
			close_out();
		end
	end

	// Main sequence
	initial begin
		logic [7:0] q;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		for (int i = 0; i < 4; i++) begin
			u_rog_host.rd(8'h9c + 8'(i), q);
			ck(q, rv[i]);
		end
		ck({1'b0, sda_out, conv_fpwm, conv_en}, 8'h27);
		u_rog_host.wr(8'h9c, 8'hff);
		u_rog_host.rd(8'h9c, q);
		ck(q, 8'h3f);
		for (int i = 0; i < 3; i++) begin
			u_rog_host.wr(8'h9c, 8'h3f ^ (8'h09 << i));
			ck({2'b0, conv_fpwm, conv_en}, 8'h3f ^ (8'h09 << i));
		end
		pe <= 3'h2;
		u_rog_host.w(4);
		ck(8'(conv_en), 8'h02);
		pe <= 3'h7;
		gg <= 3'h7;
		lv <= 3'h4;
		u_rog_host.w(8);
		ck({5'h0, o4, o2, o1}, 8'h07);
		hl <= 3'h0;
		u_rog_host.w(4);
		ck(8'(o2), 8'h00);
		for (int i = 4; i < 8; i++) begin
			u_rog_host.wr(8'h9f, 8'hf0 ^ (8'h01 << i));
			ck(8'(switch_en), 8'h0f ^ (8'h01 << (i - 4)));
		end
		u_rog_host.wr(8'h9f, 8'hff);
		u_rog_host.rd(8'h9f, q);
		ck(q, 8'hf0);
		gg <= 3'h5;
		u_rog_host.w(4);
		ck(8'(switch_en), 8'h0e);
		u_rog_host.wr(8'h9d, 8'hb5);
		u_rog_host.rd(8'h9d, q);
		ck(q, 8'hb5);
		gg <= 3'h0;
		u_rog_host.w(4);
		ck(8'(o1), 8'h00);
		gg <= 3'h7;
		u_rog_host.w(30000);
		ck(8'(o1), 8'h00);
		// Host-driven output one ignores its pending delay; termination ungated
		s1 <= ROG_SRC_HOST;
		hl <= 3'h1;
		tu <= 1'b0;
		u_rog_host.w(4);
		ck({5'h0, o4, o2, o1}, 8'h05);
		ck(8'(switch_en), 8'h0f);
		s1 <= ROG_SRC_GOOD;
		u_rog_host.w(4);
		ck(8'(o1), 8'h00);
		close_out();
	end
endmodule

//--- verification/rog_regs_sva.sv
// Port assertions for the override and delay register bank
// Assumes binding to rog_regs; sees its ports only
`timescale 1ns/100ps
module rog_regs_sva
	import rog_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_oe,
	input wire logic [2:0] conv_pin_en,
	input wire logic [3:0] switch_pin_en,
	input wire logic [2:0] group_good,
	input wire logic [2:0] lvl_in,
	input wire logic [2:0] host_lvl,
	input wire rog_src_t out1_src,
	input wire rog_src_t out2_src,
	input wire rog_src_t out4_src,
	input wire logic out2_term_use,
	input wire logic [2:0] conv_en,
	input wire logic [2:0] conv_fpwm,
	input wire logic [3:0] switch_en,
	input wire logic general_output_one,
	input wire logic general_output_two,
	input wire logic general_output_four
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// Group sources low long enough to clear delayed good
	sequence s_out1_low;
		(out1_src == ROG_SRC_GOOD && !group_good[0]) [*3];
	endsequence
	sequence s_term_low;
		(out2_term_use && !group_good[1]) [*3];
	endsequence

	// Enables never exceed pins; good levels follow their causes
	a_conv_pin_gate: assert property ((conv_en & ~$past(conv_pin_en)) == 3'h0)
		else $error("converter on without pin");
	a_switch_pin_gate: assert property ((switch_en & ~$past(switch_pin_en)) == 4'h0)
		else $error("switch on without pin");
	a_out1_clear: assert property (s_out1_low |-> !general_output_one)
		else $error("output one stays high after drop");
	a_out1_cause: assert property ($rose(general_output_one) && out1_src == ROG_SRC_GOOD
		|-> $past(group_good[0], 2))
		else $error("output one rose without good");
	a_out4_lvl_clear: assert property ((out4_src == ROG_SRC_LVL && !lvl_in[2]) [*3]
		|-> !general_output_four)
		else $error("output four high with level low");
	a_out2_host: assert property (rst_n && out2_src == ROG_SRC_HOST
		|=> general_output_two == $past(host_lvl[1]))
		else $error("output two not host level");
	a_term_gate: assert property (s_term_low |-> !switch_en[0])
		else $error("termination on without output two good");
	a_fpwm_quiet: assert property ($stable(scl_in) [*8] |=> $stable(conv_fpwm))
		else $error("mode changed without bus traffic");
	a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
		else $error("data pulled while clock high");
endmodule

bind rog_regs rog_regs_sva u_rog_regs_sva (.*);
